// file: core/ipw_pkg.sv
// Package for the indexed-port supervision timer: port codes, indices, values, timing.
// Assumes a 100 MHz core clock and byte-wide index/data ports.
package ipw_pkg;
  localparam logic [7:0] IPW_UNLOCK_BYTE = 8'h87;
  localparam logic [7:0] IPW_IDX_LUN = 8'h07;
  localparam logic [7:0] IPW_IDX_ACT = 8'h30;
  localparam logic [7:0] IPW_IDX_TBASE = 8'hF0;
  localparam logic [7:0] IPW_IDX_COUNT = 8'hF1;
  localparam logic [7:0] IPW_LUN_SUPERVISION = 8'h08;
  localparam logic [7:0] IPW_TBASE_SEC = 8'h00;
  localparam logic [7:0] IPW_TBASE_MIN = 8'h08;
  localparam logic [7:0] IPW_ZERO = 8'h00;
  localparam logic [7:0] IPW_ACT_RESET = 8'h01;
  localparam logic [7:0] IPW_DATA_ZERO = 8'h00;
  localparam int IPW_CLK_HZ = 100000000;
  localparam int IPW_TICK_S = 1;
  localparam int IPW_SEC_CYCLES = IPW_CLK_HZ * IPW_TICK_S;
  localparam int IPW_SEC_PER_MIN = 60;
  localparam int IPW_RST_PULSE_NS = 1000;
  localparam int IPW_CLK_NS = 10;
  localparam int IPW_RST_CYCLES = (IPW_RST_PULSE_NS + IPW_CLK_NS - 1) / IPW_CLK_NS;
  typedef enum logic [1:0] {
    IPW_LOCKED = 2'b00,
    IPW_HALF = 2'b01,
    IPW_OPEN = 2'b10
  } ipw_lock_t;
endpackage

// file: core/ipw_tick.sv
// Time-base tick generator for the supervision timer.
// Assumes clk at the package rate; restart_i realigns the prescaler.
`timescale 1ns/1ns
module ipw_tick
  import ipw_pkg::*;
#(
  parameter int SEC_CYCLES = IPW_SEC_CYCLES
)
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic restart_i,
  input wire logic minute_i,
  output logic tick_o
);
  logic [31:0] pre_reg;
  logic [5:0] sec_reg;
  logic sec_end;
  logic [5:0] sec_last;

  assign sec_end = (pre_reg == 32'(SEC_CYCLES - 1));
  assign sec_last = minute_i ? 6'(IPW_SEC_PER_MIN - 1) : 6'h00;

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i || (ce_i && (restart_i || sec_end)))
      pre_reg <= 32'h0;
    else if (ce_i)
      pre_reg <= pre_reg + 32'h1;
  end

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
      sec_reg <= 6'h00;
    else if (ce_i && restart_i)
      sec_reg <= 6'h00;
    else if (ce_i && sec_end)
      sec_reg <= (sec_reg >= sec_last) ? 6'h00 : sec_reg + 6'h01;
  end

  // One-cycle tick per selected unit
  assign tick_o = ce_i && !restart_i && sec_end && (sec_reg >= sec_last);
endmodule

// file: core/ipw_watchdog.sv
// Supervision timer reached through an index/data I/O port pair.
// Assumes one-cycle write/read strobes on the index and data ports, synchronous to clk_i.
`timescale 1ns/1ns
module ipw_watchdog
  import ipw_pkg::*;
#(
  parameter int SEC_CYCLES = IPW_SEC_CYCLES
)
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic idx_wr_i,
  input wire logic data_wr_i,
  input wire logic data_rd_i,
  input wire logic [7:0] wdata_i,
  output logic [7:0] rdata_o,
  output logic sys_rst_o,
  output logic running_o
);
  ipw_lock_t lock_reg;
  logic [7:0] index_reg;
  logic [7:0] lun_reg;
  logic [7:0] act_reg;
  logic [7:0] tbase_reg;
  logic [7:0] count_reg;
  logic [7:0] remain_reg;
  logic [7:0] rdata_reg;
  logic [7:0] pulse_reg;
  logic sel;
  logic wr_act;
  logic wr_tbase;
  logic wr_count;
  logic tick;
  logic active;

  function automatic logic hit(input logic [7:0] idx, input logic [7:0] want);
    hit = (idx == want);
  endfunction

  // Unlock sequence
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
      lock_reg <= IPW_LOCKED;
    else if (ce_i && idx_wr_i)
    begin
      case (lock_reg)
        IPW_LOCKED: lock_reg <= hit(wdata_i, IPW_UNLOCK_BYTE) ? IPW_HALF : IPW_LOCKED;
        IPW_HALF: lock_reg <= hit(wdata_i, IPW_UNLOCK_BYTE) ? IPW_OPEN : IPW_LOCKED;
        IPW_OPEN: lock_reg <= IPW_OPEN;
        default: lock_reg <= IPW_LOCKED;
      endcase
    end
  end

  // Index latch
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
      index_reg <= IPW_ZERO;
    else if (ce_i && idx_wr_i && lock_reg == IPW_OPEN)
      index_reg <= wdata_i;
  end

  assign sel = hit(lun_reg, IPW_LUN_SUPERVISION);
  assign wr_act = ce_i && data_wr_i && lock_reg == IPW_OPEN && sel && hit(index_reg, IPW_IDX_ACT);
  assign wr_tbase = ce_i && data_wr_i && lock_reg == IPW_OPEN && sel
    && hit(index_reg, IPW_IDX_TBASE);
  assign wr_count = ce_i && data_wr_i && lock_reg == IPW_OPEN && sel
    && hit(index_reg, IPW_IDX_COUNT);

  // Register writes
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      lun_reg <= IPW_ZERO;
      act_reg <= IPW_ACT_RESET;
      tbase_reg <= IPW_TBASE_SEC;
      count_reg <= IPW_ZERO;
    end
    else if (ce_i && data_wr_i && lock_reg == IPW_OPEN)
    begin
      if (hit(index_reg, IPW_IDX_LUN))
        lun_reg <= wdata_i;
      if (wr_act)
        act_reg <= wdata_i;
      if (wr_tbase)
        tbase_reg <= wdata_i;
      if (wr_count)
        count_reg <= wdata_i;
    end
  end

  // Read data path
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
      rdata_reg <= IPW_DATA_ZERO;
    else if (ce_i && data_rd_i)
    begin
      if (lock_reg != IPW_OPEN)
        rdata_reg <= IPW_DATA_ZERO;
      else if (hit(index_reg, IPW_IDX_LUN))
        rdata_reg <= lun_reg;
      else if (!sel)
        rdata_reg <= IPW_DATA_ZERO;
      else if (hit(index_reg, IPW_IDX_ACT))
        rdata_reg <= act_reg;
      else if (hit(index_reg, IPW_IDX_TBASE))
        rdata_reg <= tbase_reg;
      else if (hit(index_reg, IPW_IDX_COUNT))
        rdata_reg <= remain_reg;
      else
        rdata_reg <= IPW_DATA_ZERO;
    end
  end
  assign rdata_o = rdata_reg;

  // Zero activation or zero count stops the timer
  assign active = (act_reg != IPW_ZERO) && (remain_reg != IPW_ZERO);
  assign running_o = active;

  ipw_tick #(
    .SEC_CYCLES(SEC_CYCLES)
  ) u_tick (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .ce_i(ce_i),
    .restart_i(wr_count || !active),
    .minute_i(hit(tbase_reg, IPW_TBASE_MIN)),
    .tick_o(tick)
  );

  // Countdown
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
      remain_reg <= IPW_ZERO;
    else if (ce_i)
    begin
      if (wr_count)
        remain_reg <= wdata_i;
      else if (wr_act && wdata_i == IPW_ZERO)
        remain_reg <= IPW_ZERO;
      else if (active && tick)
        remain_reg <= remain_reg - 8'h01;
    end
  end

  // Expiry raises a fixed-width reset pulse
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
      pulse_reg <= IPW_ZERO;
    else if (ce_i)
    begin
      if (active && tick && remain_reg == 8'h01 && !wr_count
        && !(wr_act && wdata_i == IPW_ZERO))
        pulse_reg <= 8'(IPW_RST_CYCLES);
      else if (pulse_reg != IPW_ZERO)
        pulse_reg <= pulse_reg - 8'h01;
    end
  end
  assign sys_rst_o = (pulse_reg != IPW_ZERO);

  unlock_two_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (ce_i && idx_wr_i && lock_reg == IPW_LOCKED && wdata_i != IPW_UNLOCK_BYTE)
    |=> lock_reg == IPW_LOCKED) else $error("unlock advanced on wrong byte");
  half_relock_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (ce_i && idx_wr_i && lock_reg == IPW_HALF && wdata_i != IPW_UNLOCK_BYTE)
    |=> lock_reg == IPW_LOCKED) else $error("half unlock kept on wrong byte");
  locked_ignore_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (ce_i && data_wr_i && (lock_reg != IPW_OPEN || !sel)) |=> act_reg == $past(act_reg)
    && tbase_reg == $past(tbase_reg) && count_reg == $past(count_reg))
    else $error("register written while closed");
  read_locked_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (ce_i && data_rd_i && lock_reg != IPW_OPEN) |=> rdata_o == IPW_DATA_ZERO)
    else $error("read data shown while locked");
  index_latch_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (ce_i && idx_wr_i && lock_reg == IPW_OPEN) |=> index_reg == $past(wdata_i))
    else $error("index not latched");
  read_count_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (ce_i && data_rd_i && lock_reg == IPW_OPEN && sel && hit(index_reg, IPW_IDX_COUNT))
    |=> rdata_o == $past(remain_reg)) else $error("count read wrong");
  tbase_store_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    wr_tbase |=> tbase_reg == $past(wdata_i)) else $error("time base not stored");
  count_reload_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    wr_count |=> remain_reg == $past(wdata_i)) else $error("count not reloaded");
  zero_count_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (wr_count && wdata_i == IPW_ZERO) |=> !running_o ##1 !$rose(sys_rst_o))
    else $error("zero count kept timer running");
  idle_quiet_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (ce_i && !active && !sys_rst_o) |=> !sys_rst_o)
    else $error("reset raised while stopped");
  freeze_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !ce_i |=> remain_reg == $past(remain_reg) && pulse_reg == $past(pulse_reg)
    && lock_reg == $past(lock_reg)) else $error("state moved while frozen");
  act_store_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    wr_act |=> act_reg == $past(wdata_i)) else $error("activation not stored");
  disable_now_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (wr_act && wdata_i == IPW_ZERO) |=> !running_o && remain_reg == IPW_ZERO)
    else $error("activation zero did not stop timer");
  expiry_reset_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (ce_i && active && tick && remain_reg == 8'h01 && !wr_count
    && !(wr_act && wdata_i == IPW_ZERO))
    |=> sys_rst_o && remain_reg == IPW_ZERO) else $error("expiry gave no reset");
  expiry_only_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    $rose(sys_rst_o) |-> $past(remain_reg) == 8'h01 && remain_reg == IPW_ZERO)
    else $error("reset without expiry");
  tick_gate_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (ce_i && active && !tick && !wr_count && !wr_act) |=> remain_reg == $past(remain_reg))
    else $error("count moved without tick");
  minute_unit_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (tick && hit(tbase_reg, IPW_TBASE_MIN)) |-> u_tick.sec_reg == 6'(IPW_SEC_PER_MIN - 1))
    else $error("minute tick early");
endmodule

// file: test/ipw_host.sv
// Host model driving the index/data port pair of the supervision timer.
// Assumes the device clock; one strobe at a time, taken at the next edge.
`timescale 1ns/1ns
module ipw_host
  import ipw_pkg::*;
(
  input wire logic clk_i,
  input wire logic [7:0] rdata_i,
  output logic idx_wr_o,
  output logic data_wr_o,
  output logic data_rd_o,
  output logic [7:0] wdata_o
);
  initial
  begin
    idx_wr_o = 1'b0;
    data_wr_o = 1'b0;
    data_rd_o = 1'b0;
    wdata_o = 8'h00;
  end
  // Kind 0 index write, 1 data write, 2 data read
  task automatic acc(input int k, input logic [7:0] b);
    @(posedge clk_i);
    idx_wr_o <= (k == 0);
    data_wr_o <= (k == 1);
    data_rd_o <= (k == 2);
    wdata_o <= b;
    @(posedge clk_i);
    idx_wr_o <= 1'b0;
    data_wr_o <= 1'b0;
    data_rd_o <= 1'b0;
    wdata_o <= ~b;
    #1;
  endtask
  task automatic wr(input logic [7:0] i, input logic [7:0] b);
    acc(0, i);
    acc(1, b);
  endtask
  task automatic rd(input logic [7:0] i, output logic [7:0] v);
    acc(0, i);
    acc(2, 8'h00);
    #1;
    v = rdata_i;
  endtask
  task automatic open();
    acc(0, IPW_UNLOCK_BYTE);
    acc(0, IPW_UNLOCK_BYTE);
    wr(IPW_IDX_LUN, IPW_LUN_SUPERVISION);
  endtask
endmodule

// file: test/indexed_port_watchdog_test.sv
// Self-checking bench for the supervision timer with a shortened second.
// Assumes the host model in ipw_host.sv.
`timescale 1ns/1ns
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin failures++; \
  $display("mismatch t=%0t got %h exp %h", $time, a, b); end end
module indexed_port_watchdog_test;
  import ipw_pkg::*;
  localparam int SEC = 10;
  logic clk_i, rst_n_i, ce_i, iw, dw, dr, srst, run;
  logic [7:0] wd, rdat, v;
  int failures = 0;
  int total_checks = 0;
  ipw_watchdog #(.SEC_CYCLES(SEC)) dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i),
    .idx_wr_i(iw), .data_wr_i(dw), .data_rd_i(dr), .wdata_i(wd), .rdata_o(rdat),
    .sys_rst_o(srst), .running_o(run));
  ipw_host h (.clk_i(clk_i), .rdata_i(rdat), .idx_wr_o(iw), .data_wr_o(dw),
    .data_rd_o(dr), .wdata_o(wd));
  initial
  begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  task automatic end_sim();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // Waits for the reset pulse about e cycles on, then measures its width
  task automatic wait_rst(input int e);
    int n;
    int w;
    n = 0;
    w = 0;
    while (srst !== 1'b1 && n < e + 8)
    begin
      @(posedge clk_i);
      #1;
      n++;
    end
    `CHK(n >= e - 4 && n <= e + 4, 1'b1)
    if (n >= e + 8)
      end_sim();
    while (srst === 1'b1 && w < 200)
    begin
      @(posedge clk_i);
      #1;
      w++;
    end
    `CHK(w, IPW_RST_CYCLES)
    `CHK(run, 1'b0)
  endtask
  task automatic quiet(input int c);
    int k;
    k = 0;
    repeat (c)
    begin
      @(posedge clk_i);
      k += (srst !== 1'b0);
    end
    `CHK(k, 0)
  endtask
  task automatic t_lock();
    h.wr(IPW_IDX_COUNT, 8'h05);
    h.acc(0, IPW_UNLOCK_BYTE);
    h.acc(0, IPW_IDX_LUN);
    h.acc(0, IPW_UNLOCK_BYTE);
    h.wr(IPW_IDX_COUNT, 8'h05);
    h.rd(IPW_IDX_COUNT, v);
    `CHK(v, IPW_DATA_ZERO)
    `CHK(run, 1'b0)
    $display("test lock done");
  endtask
  task automatic t_sec();
    h.open();
    h.rd(IPW_IDX_LUN, v);
    `CHK(v, IPW_LUN_SUPERVISION)
    h.wr(IPW_IDX_TBASE, IPW_TBASE_SEC);
    h.wr(IPW_IDX_COUNT, 8'h03);
    h.rd(IPW_IDX_COUNT, v);
    `CHK(v, 8'h03)
    `CHK(run, 1'b1)
    wait_rst(3 * SEC - 4);
    $display("test seconds done");
  endtask
  task automatic t_reload();
    h.wr(IPW_IDX_COUNT, 8'h02);
    repeat (15) @(posedge clk_i);
    h.wr(IPW_IDX_COUNT, 8'h02);
    wait_rst(2 * SEC);
    h.wr(IPW_IDX_COUNT, 8'h02);
    `CHK(run, 1'b1)
    h.wr(IPW_IDX_COUNT, IPW_ZERO);
    `CHK(run, 1'b0)
    quiet(50);
    $display("test reload done");
  endtask
  task automatic t_min();
    h.wr(IPW_IDX_TBASE, IPW_TBASE_MIN);
    h.wr(IPW_IDX_COUNT, 8'h01);
    wait_rst(IPW_SEC_PER_MIN * SEC);
    $display("test minutes done");
  endtask
  task automatic t_off();
    h.wr(IPW_IDX_COUNT, 8'h05);
    @(posedge clk_i);
    ce_i <= 1'b0;
    quiet(80);
    `CHK(run, 1'b1)
    ce_i <= 1'b1;
    h.wr(IPW_IDX_ACT, IPW_ZERO);
    `CHK(run, 1'b0)
    quiet(80);
    h.rd(IPW_IDX_ACT, v);
    `CHK(v, IPW_ZERO)
    $display("test disable done");
  endtask
  initial
  begin
    rst_n_i = 1'b0;
    ce_i = 1'b1;
    repeat (20) @(posedge clk_i);
    rst_n_i <= 1'b1;
    t_lock();
    t_sec();
    t_reload();
    t_min();
    t_off();
    end_sim();
  end
endmodule
